//--- common/dshp_map.svh
// Offsets, field codes and counts for the serial host port.
// Assumes inclusion by bare name from the core file.
`ifndef DSHP_MAP_SVH
`define DSHP_MAP_SVH

// --------------------------------------------------------------
// Frame geometry
// --------------------------------------------------------------
`define DSHP_SPI_FRAME_BITS 24
`define DSHP_SPI_CNT_W 5
`define DSHP_RW_BIT 23

// --------------------------------------------------------------
// Bus addressing and general call
// --------------------------------------------------------------
`define DSHP_ADDR_FIXED 4'h9
`define DSHP_GC_ADDR 8'h00
`define DSHP_GC_RESET 8'h06

// --------------------------------------------------------------
// Command byte codes
// --------------------------------------------------------------
`define DSHP_CMD_NOOP 7'h00
`define DSHP_CMD_LAST 7'h09

// --------------------------------------------------------------
// Synchronised input vector positions
// --------------------------------------------------------------
`define DSHP_IN_N 7
`define DSHP_IN_FSEL 0
`define DSHP_IN_SCLK 1
`define DSHP_IN_SDI 2
`define DSHP_IN_SCL 3
`define DSHP_IN_SDA 4
`define DSHP_IN_ASTRAP 5
`define DSHP_IN_MODE 6

// Cycles after reset release before the mode strap is caught
`define DSHP_STRAP_WAIT 3'h4

`endif

//--- common/dshp_pkg.sv
// Types shared by the serial host port and its bench.
// Uses no constants from the header, so needs no include path.
package dshp_pkg;

  // Register write request handed to the register file
  typedef struct packed {
    logic [7:0] cmd;   // Register code, read/write flag removed
    logic [15:0] data; // High byte then low byte
  } dshp_wr_t;

  // Two-wire slave states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, // Waiting for a start
    ST_RX = 3'b001,   // Shifting a byte in
    ST_ACK = 3'b010,  // Holding the data line low for the ninth clock
    ST_TX = 3'b011,   // Shifting a byte out
    ST_RACK = 3'b100, // Sampling the master's acknowledge
    ST_SKIP = 3'b101  // Not addressed or transfer over, waiting for next start
  } dshp_state_t;

endpackage

//--- core/dshp_host_port.sv
// Serial host port: three-wire write port and two-wire slave port.
// Assumes pins arrive asynchronously and a register file sits outside,
// taking write requests and returning read data for rd_cmd_out.
//
// Summary of operation
// - SPI frames need 24 falling edges; update on rise
// - Early frame-select rise aborts and clears shift register
// - Aborted frame changes no register or mode
// - Strap high at power-up selects two-wire mode
// - Two-wire side is slave only, never drives clock
// - Same protocol at 100k, 400k and 1M rates
// - Only seven-bit addresses; ten-bit never matches
// - General call 00 then 06 triggers software reset
// - Reset fires at falling edge of second acknowledge
// - Ninth clock carries acknowledge, low means acknowledged
// - Start detected in every state
// - After stop release data line and idle
// - Data changes only while clock is low
// - Acknowledge address only on a match or a general call
// - Direction bit steers data; receiver acknowledges bytes
// - Every write byte after a matching address is acknowledged; a general call acknowledges only 00 and 06
// - Write applied at falling edge of last acknowledge
// - Address is 1001 plus three strap-decoded bits
// - Strap sampled during first byte, latched per frame
// - First byte: seven address bits plus direction flag
// - Command codes: 0 no-op, 1..9 registers
// - Read: command write, repeated start, two bytes out
// - SPI shift register holds 24 bits per frame
// - Frame-select fall starts frame; high blocks inputs
`timescale 1ns/100ps
`include "dshp_map.svh"

module dshp_host_port #(
  parameter int FRAME_BITS = `DSHP_SPI_FRAME_BITS // Bits per three-wire frame
) (
  input wire logic clk_sys_in, // System clock, 10 MHz
  input wire logic rst_n_in, // Synchronous reset, active low
  input wire logic interface_select_strap_in, // Mode strap, high for two-wire
  input wire logic frame_sel_n_in, // Three-wire frame select, active low
  input wire logic sclk_in, // Three-wire serial clock
  input wire logic serial_data_in_in, // Three-wire serial data
  input wire logic scl_in, // Two-wire clock, input only
  input wire logic sda_in, // Two-wire data level on the wire
  input wire logic address_strap_pin_in, // Address strap pin
  input wire logic [15:0] rd_data_in, // Register value for rd_cmd_out
  output logic sda_out, // Data drive value, always low
  output logic sda_oe_out, // High while pulling data low
  output logic i2c_mode_out, // Latched interface mode
  output logic wr_valid_out, // One-cycle write strobe
  output dshp_pkg::dshp_wr_t wr_req_out, // Write request
  output logic [7:0] rd_cmd_out, // Register selected for reads
  output logic soft_reset_out, // One-cycle software reset
  output logic spi_abort_out // One-cycle aborted-frame pulse
);

  // --------------------------------------------------------------
  // Elaboration check
  // --------------------------------------------------------------
  // Counter width and the command field position fix the frame size
  if (FRAME_BITS != `DSHP_SPI_FRAME_BITS) begin : g_bad_frame
    $error("FRAME_BITS must equal the 24-bit frame");
  end

  // --------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------
  logic [`DSHP_IN_N-1:0] raw; // Pins gathered into one vector
  logic [`DSHP_IN_N-1:0] s1_r; // First stage, read only by s2_r
  logic [`DSHP_IN_N-1:0] s2_r; // Second stage
  logic [`DSHP_IN_N-1:0] s3_r; // Third stage
  logic [`DSHP_IN_N-1:0] filt_r; // Accepted level
  logic [`DSHP_IN_N-1:0] prev_r; // Accepted level one cycle earlier
  logic [`DSHP_IN_N-1:0] agree; // Stages two and three agree

  assign raw = {interface_select_strap_in, address_strap_pin_in, sda_in, scl_in,
                serial_data_in_in, sclk_in, frame_sel_n_in};
  assign agree = ~(s2_r ^ s3_r);

  // Three flops; a change counts only once stages two and three agree
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      s1_r <= '1;
      s2_r <= '1;
      s3_r <= '1;
      filt_r <= '1;
      prev_r <= '1;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_r <= (filt_r & ~agree) | (s2_r & agree);
      prev_r <= filt_r;
    end
  end

  // Edge events of the accepted levels
  logic scl, sda, scl_rise, scl_fall, sda_rise, sda_fall;
  logic fsel_rise, fsel_fall, sclk_fall;
  assign scl = filt_r[`DSHP_IN_SCL];
  assign sda = filt_r[`DSHP_IN_SDA];
  assign scl_rise = scl & ~prev_r[`DSHP_IN_SCL];
  assign scl_fall = ~scl & prev_r[`DSHP_IN_SCL];
  assign sda_rise = sda & ~prev_r[`DSHP_IN_SDA];
  assign sda_fall = ~sda & prev_r[`DSHP_IN_SDA];
  assign fsel_rise = filt_r[`DSHP_IN_FSEL] & ~prev_r[`DSHP_IN_FSEL];
  assign fsel_fall = ~filt_r[`DSHP_IN_FSEL] & prev_r[`DSHP_IN_FSEL];
  assign sclk_fall = ~filt_r[`DSHP_IN_SCLK] & prev_r[`DSHP_IN_SCLK];

  // --------------------------------------------------------------
  // Mode strap capture
  // --------------------------------------------------------------
  logic [2:0] strap_wait_r; // Lets the synchroniser settle first
  logic mode_done_r; // Strap has been caught
  logic i2c_mode_r; // Latched mode, kept until next reset

  // Caught once after reset release; later strap changes are ignored
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      strap_wait_r <= 3'h0;
      mode_done_r <= 1'b0;
      i2c_mode_r <= 1'b0;
    end else if (!mode_done_r) begin
      if (strap_wait_r == `DSHP_STRAP_WAIT) begin
        mode_done_r <= 1'b1;
        i2c_mode_r <= filt_r[`DSHP_IN_MODE];
      end else begin
        strap_wait_r <= strap_wait_r + 3'h1;
      end
    end
  end

  // --------------------------------------------------------------
  // Three-wire shift path
  // --------------------------------------------------------------
  logic [FRAME_BITS-1:0] spi_sh_r; // Input shift register
  logic [`DSHP_SPI_CNT_W-1:0] spi_cnt_r; // Falling edges seen, saturating
  logic spi_act; // Three-wire mode and idle-safe
  logic spi_full; // Enough edges for a write
  logic spi_fire; // Write at frame-select rise
  logic [6:0] spi_cmd; // Command without read flag

  assign spi_act = mode_done_r & ~i2c_mode_r;
  assign spi_full = (spi_cnt_r == `DSHP_SPI_CNT_W'(FRAME_BITS));
  assign spi_cmd = spi_sh_r[`DSHP_RW_BIT-1 -: 7];
  // NOOP and unknown codes reach no register
  assign spi_fire = spi_act & fsel_rise & spi_full & ~spi_sh_r[`DSHP_RW_BIT] &
                    (spi_cmd != `DSHP_CMD_NOOP) & (spi_cmd <= `DSHP_CMD_LAST);

  // Clock and data only count while frame select is low
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      spi_sh_r <= '0;
      spi_cnt_r <= '0;
    end else if (spi_act) begin
      if (fsel_fall || fsel_rise) begin
        // Fresh frame, or early rise wipes partial bits
        spi_sh_r <= '0;
        spi_cnt_r <= '0;
      end else if (!filt_r[`DSHP_IN_FSEL] && sclk_fall) begin
        spi_sh_r <= {spi_sh_r[FRAME_BITS-2:0], filt_r[`DSHP_IN_SDI]};
        if (!spi_full) begin
          spi_cnt_r <= spi_cnt_r + `DSHP_SPI_CNT_W'(1);
        end
      end
    end
  end

  // --------------------------------------------------------------
  // Two-wire slave
  // --------------------------------------------------------------
  dshp_pkg::dshp_state_t st_r; // Slave state
  logic [3:0] bit_r; // Clock rises within the byte
  logic [1:0] byte_r; // 0 address, 1 command, 2 high, 3 low
  logic [7:0] sh_r; // Receive shift register
  logic [7:0] tx_r; // Transmit shift register
  logic [7:0] hi_r; // Received high data byte
  logic [7:0] cmd_r; // Last command byte
  logic rw_r; // Direction flag of this transfer
  logic gc_r; // Transfer is a general call
  logic gc_go_r; // Reset pending on this acknowledge
  logic tx_lo_r; // Low byte is being sent
  logic oe_r; // Pull data low
  logic st_lo_r, st_hi_r, st_dsda_r, st_dscl_r; // Strap observations
  logic [2:0] strap_code; // Decoded lower address bits
  logic [2:0] strap_r; // Address bits latched for the frame
  logic addr_hit; // Received address is ours
  logic i2c_fire; // Write at last acknowledge fall
  logic start_ev, stop_ev; // Bus conditions

  assign start_ev = i2c_mode_r & scl & sda_fall;
  assign stop_ev = i2c_mode_r & scl & sda_rise;

  // Strap tied low, high, to the data line, or to the clock line
  always_comb begin
    if (!st_hi_r) begin
      strap_code = 3'h0;
    end else if (!st_lo_r) begin
      strap_code = 3'h1;
    end else if (!st_dsda_r) begin
      strap_code = 3'h2;
    end else begin
      strap_code = 3'h3;
    end
  end

  // Only 1001xxx matches, so ten-bit prefixes fall through
  assign addr_hit = (sh_r[7:1] == {`DSHP_ADDR_FIXED, strap_code});
  assign i2c_fire = (st_r == dshp_pkg::ST_ACK) & scl_fall & (byte_r == 2'h3) & ~rw_r &
                    ~gc_r & (cmd_r[6:0] != `DSHP_CMD_NOOP) &
                    (cmd_r[6:0] <= `DSHP_CMD_LAST);

  // Strap watch runs through the address byte of every frame
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in || start_ev) begin
      st_lo_r <= 1'b0;
      st_hi_r <= 1'b0;
      st_dsda_r <= 1'b0;
      st_dscl_r <= 1'b0;
    end else if (st_r == dshp_pkg::ST_RX && byte_r == 2'h0) begin
      st_lo_r <= st_lo_r | ~filt_r[`DSHP_IN_ASTRAP];
      st_hi_r <= st_hi_r | filt_r[`DSHP_IN_ASTRAP];
      st_dsda_r <= st_dsda_r | (filt_r[`DSHP_IN_ASTRAP] ^ sda);
      st_dscl_r <= st_dscl_r | (filt_r[`DSHP_IN_ASTRAP] ^ scl);
    end
  end

  // Byte engine; data drive changes only after a clock fall
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in || !i2c_mode_r) begin
      st_r <= dshp_pkg::ST_IDLE;
      bit_r <= 4'h0;
      byte_r <= 2'h0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      hi_r <= 8'h00;
      cmd_r <= 8'h00;
      rw_r <= 1'b0;
      gc_r <= 1'b0;
      gc_go_r <= 1'b0;
      tx_lo_r <= 1'b0;
      oe_r <= 1'b0;
      strap_r <= 3'h0;
    end else if (start_ev) begin
      // Start or repeated start wins over any state
      st_r <= dshp_pkg::ST_RX;
      bit_r <= 4'h0;
      byte_r <= 2'h0;
      gc_r <= 1'b0;
      gc_go_r <= 1'b0;
      oe_r <= 1'b0;
    end else if (stop_ev) begin
      st_r <= dshp_pkg::ST_IDLE;
      oe_r <= 1'b0;
    end else begin
      case (st_r)
        dshp_pkg::ST_RX: begin
          if (scl_rise) begin
            sh_r <= {sh_r[6:0], sda};
            bit_r <= bit_r + 4'h1;
          end else if (scl_fall && bit_r == 4'h8) begin
            bit_r <= 4'h0;
            st_r <= dshp_pkg::ST_ACK;
            oe_r <= 1'b1;
            if (byte_r == 2'h0) begin
              strap_r <= strap_code;
              rw_r <= sh_r[0];
              if (sh_r == `DSHP_GC_ADDR) begin
                gc_r <= 1'b1;
              end else if (!addr_hit) begin
                st_r <= dshp_pkg::ST_SKIP;
                oe_r <= 1'b0;
              end
            end else if (byte_r == 2'h1) begin
              if (gc_r) begin
                gc_go_r <= (sh_r == `DSHP_GC_RESET);
                st_r <= (sh_r == `DSHP_GC_RESET) ? dshp_pkg::ST_ACK : dshp_pkg::ST_SKIP;
                oe_r <= (sh_r == `DSHP_GC_RESET);
              end else begin
                cmd_r <= sh_r;
              end
            end else if (byte_r == 2'h2) begin
              hi_r <= sh_r;
            end
          end
        end
        dshp_pkg::ST_ACK: begin
          if (scl_fall) begin
            oe_r <= 1'b0;
            if (gc_go_r) begin
              gc_go_r <= 1'b0;
              st_r <= dshp_pkg::ST_SKIP;
            end else if (rw_r) begin
              // Read: high byte goes out first
              tx_r <= rd_data_in[15:8];
              tx_lo_r <= 1'b0;
              oe_r <= ~rd_data_in[15];
              st_r <= dshp_pkg::ST_TX;
            end else begin
              // Further bytes after the low byte start a new data pair
              byte_r <= (byte_r == 2'h3) ? 2'h2 : byte_r + 2'h1;
              st_r <= dshp_pkg::ST_RX;
            end
          end
        end
        dshp_pkg::ST_TX: begin
          if (scl_rise) begin
            bit_r <= bit_r + 4'h1;
          end else if (scl_fall) begin
            if (bit_r == 4'h8) begin
              bit_r <= 4'h0;
              oe_r <= 1'b0;
              st_r <= dshp_pkg::ST_RACK;
            end else begin
              tx_r <= {tx_r[6:0], 1'b0};
              oe_r <= ~tx_r[6];
            end
          end
        end
        dshp_pkg::ST_RACK: begin
          if (scl_rise) begin
            // Master acknowledge after the high byte brings the low byte
            if (!sda && !tx_lo_r) begin
              tx_lo_r <= 1'b1;
            end else begin
              st_r <= dshp_pkg::ST_SKIP;
            end
          end else if (scl_fall && tx_lo_r) begin
            tx_r <= rd_data_in[7:0];
            oe_r <= ~rd_data_in[7];
            st_r <= dshp_pkg::ST_TX;
          end
        end
        default: begin
          oe_r <= 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // Output registers
  // --------------------------------------------------------------
  // Strobes come straight from flops; clock line never driven
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      wr_valid_out <= 1'b0;
      wr_req_out <= '0;
      soft_reset_out <= 1'b0;
      spi_abort_out <= 1'b0;
      sda_out <= 1'b0;
      sda_oe_out <= 1'b0;
      i2c_mode_out <= 1'b0;
      rd_cmd_out <= 8'h00;
    end else begin
      wr_valid_out <= spi_fire | i2c_fire;
      if (spi_fire) begin
        wr_req_out <= {{1'b0, spi_cmd}, spi_sh_r[15:0]};
      end else if (i2c_fire) begin
        wr_req_out <= {{1'b0, cmd_r[6:0]}, hi_r, sh_r};
      end
      soft_reset_out <= (st_r == dshp_pkg::ST_ACK) & scl_fall & gc_go_r;
      spi_abort_out <= spi_act & fsel_rise & ~spi_full;
      sda_out <= 1'b0;
      sda_oe_out <= oe_r & i2c_mode_r;
      i2c_mode_out <= i2c_mode_r;
      rd_cmd_out <= {1'b0, cmd_r[6:0]};
    end
  end

endmodule

//--- testbench/dshp_host_port_monitor.sv
// Concurrent checks on the serial host port's top-level ports.
// Assumes binding to dshp_host_port and a synchronous active-low reset.
`timescale 1ns/100ps
module dshp_host_port_monitor #(
  parameter int FRAME_BITS = 24 // Bits per three-wire frame
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic interface_select_strap_in,
  input wire logic frame_sel_n_in,
  input wire logic sclk_in,
  input wire logic serial_data_in_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic address_strap_pin_in,
  input wire logic [15:0] rd_data_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic i2c_mode_out,
  input wire logic wr_valid_out,
  input wire dshp_pkg::dshp_wr_t wr_req_out,
  input wire logic [7:0] rd_cmd_out,
  input wire logic soft_reset_out,
  input wire logic spi_abort_out
);
  // ----------------------------------------------------------
  // Shared timing
  // ----------------------------------------------------------
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // Stop: data rises while clock high
  sequence s_stop;
    scl_in && !sda_in ##1 scl_in && sda_in;
  endsequence
  // One-cycle write strobe
  sequence s_wr_pulse;
    wr_valid_out ##1 !wr_valid_out;
  endsequence
  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  chk_pin_drive_low: assert property (sda_out == 1'b0)
    else $error("drive value not low");
  chk_spi_no_drive: assert property (!i2c_mode_out |-> !sda_oe_out)
    else $error("pulled in three-wire mode");
  chk_oe_clock_low: assert property ($changed(sda_oe_out) |-> !scl_in)
    else $error("drive changed, clock high");
  chk_wr_one_pulse: assert property ($rose(wr_valid_out) |-> s_wr_pulse)
    else $error("write strobe too long");
  chk_wr_cmd_range: assert property (wr_valid_out |->
    wr_req_out.cmd >= 8'h01 && wr_req_out.cmd <= 8'h09)
    else $error("write to bad register");
  chk_wr_clock_low: assert property (wr_valid_out && i2c_mode_out |-> !scl_in)
    else $error("write not in clock low");
  chk_gc_reset_pulse: assert property (soft_reset_out |->
    i2c_mode_out && !scl_in ##1 !soft_reset_out)
    else $error("reset pulse misplaced");
  chk_spi_wr_rise: assert property (wr_valid_out && !i2c_mode_out |->
    $past(frame_sel_n_in, 3))
    else $error("write before select rose");
  chk_abort_rise: assert property (spi_abort_out |-> $past(frame_sel_n_in, 3))
    else $error("abort without select rise");
  chk_abort_no_wr: assert property (spi_abort_out |-> !wr_valid_out [*8])
    else $error("aborted frame wrote");
  chk_stop_release: assert property (s_stop |=> !sda_oe_out [*4])
    else $error("pulled after stop");
endmodule

//--- testbench/dshp_bus_master.sv
// Behavioural host: two-wire master and three-wire frame source.
// Assumes the bench resolves the open-drain data wire into sda_in.
`timescale 1ns/100ps
module dshp_bus_master (
  input wire logic clk_sys_in, // System clock paces every phase
  input wire logic sda_in, // Resolved data wire
  output logic scl_out, // Two-wire clock, push-pull from host
  output logic sda_low_out, // High while host pulls data low
  output logic frame_sel_n_out, // Frame select, active low
  output logic sclk_out, // Three-wire clock, still outside frames
  output logic sdi_out // Three-wire data
);
  // Low phase long enough for the slave's synchroniser and setup
  localparam int LO = 8;
  localparam int HI = 5;
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
    frame_sel_n_out = 1'b1;
    sclk_out = 1'b0;
    sdi_out = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  // ----------------------------------------------------------
  // Three-wire frame, n bits MSB first
  // ----------------------------------------------------------
  task automatic spi_frame(input logic [23:0] d, input int n);
    tick(1);
    frame_sel_n_out <= 1'b0;
    for (int i = 0; i < n; i++) begin
      tick(4);
      sdi_out <= d[23-i];
      sclk_out <= 1'b1;
      tick(4);
      sclk_out <= 1'b0;
    end
    tick(4);
    frame_sel_n_out <= 1'b1;
    sdi_out <= ~sdi_out; // Released line shows no stale value
    tick(8);
  endtask
  // ----------------------------------------------------------
  // Two-wire conditions and bits
  // ----------------------------------------------------------
  task automatic i2c_start();
    tick(1);
    sda_low_out <= 1'b0;
    tick(LO);
    scl_out <= 1'b1;
    tick(HI);
    sda_low_out <= 1'b1;
    tick(HI);
    scl_out <= 1'b0;
  endtask
  task automatic i2c_stop();
    tick(2);
    sda_low_out <= 1'b1;
    tick(LO - 2);
    scl_out <= 1'b1;
    tick(HI);
    sda_low_out <= 1'b0;
    tick(HI);
  endtask
  // Data changes only in the low phase; sampled at the end of high
  task automatic i2c_bit(input logic b, output logic r);
    tick(2);
    sda_low_out <= ~b;
    tick(LO - 2);
    scl_out <= 1'b1;
    tick(HI);
    r = sda_in;
    scl_out <= 1'b0;
  endtask
  task automatic i2c_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 0; i < 8; i++) i2c_bit(d[7-i], r);
    i2c_bit(1'b1, r);
    ack = ~r;
  endtask
  // Host acknowledges all but the last byte read
  task automatic i2c_read(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++) begin
      i2c_bit(1'b1, r);
      d = {d[6:0], r};
    end
    i2c_bit(last, r);
  endtask
endmodule

//--- testbench/dshp_host_port_test.sv
// Self-checking bench for the serial host port, both link modes.
// Assumes the behavioural host model and the port monitor beside it.
`timescale 1ns/100ps
module dshp_host_port_test;
  logic clk_sys_in, rst_n_in, strap, scl, sda, sda_low, fsel_n, sclk, sdi, astrap;
  logic sda_drv, sda_oe, i2c_mode, wr_valid, soft_rst, abort_p;
  logic [1:0] asel; // Address strap wiring: ground, supply, data, clock
  logic [15:0] rd_data;
  logic [7:0] rd_cmd;
  dshp_pkg::dshp_wr_t wr_req, wr_last;
  int miscompares = 0, compares = 0, wr_cnt = 0, gc_cnt = 0, ab_cnt = 0;
  // Open-drain wire with pull-up
  assign sda = !(sda_low | (sda_oe & !sda_drv));
  always_comb case (asel)
    2'h0: astrap = 1'b0;
    2'h1: astrap = 1'b1;
    2'h2: astrap = sda;
    default: astrap = scl;
  endcase
  always #50 clk_sys_in = ~clk_sys_in;
  // Pulse counters seen at the ports
  always @(posedge clk_sys_in) begin
    if (wr_valid === 1'b1) begin
      wr_cnt++;
      wr_last = wr_req;
    end
    if (soft_rst === 1'b1) gc_cnt++;
    if (abort_p === 1'b1) ab_cnt++;
  end
  dshp_host_port u_dshp_host_port (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .interface_select_strap_in(strap), .frame_sel_n_in(fsel_n), .sclk_in(sclk),
    .serial_data_in_in(sdi), .scl_in(scl), .sda_in(sda), .address_strap_pin_in(astrap),
    .rd_data_in(rd_data), .sda_out(sda_drv), .sda_oe_out(sda_oe), .i2c_mode_out(i2c_mode),
    .wr_valid_out(wr_valid), .wr_req_out(wr_req), .rd_cmd_out(rd_cmd),
    .soft_reset_out(soft_rst), .spi_abort_out(abort_p));
  dshp_bus_master u_dshp_bus_master (.clk_sys_in(clk_sys_in), .sda_in(sda),
    .scl_out(scl), .sda_low_out(sda_low), .frame_sel_n_out(fsel_n), .sclk_out(sclk),
    .sdi_out(sdi));
  // ----------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------
  task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("Counts: %0d compares, %0d miscompares", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Bounded wait for counter c to reach n
  task automatic wait_cnt(ref int c, input int n);
    for (int i = 0; i < 60 && c < n; i++) @(posedge clk_sys_in);
    if (c < n) begin
      $display("CHECK FAILED at %0t: pulse never came", $time);
      miscompares++;
      end_sim();
    end
  endtask
  task automatic do_reset(input logic s);
    @(posedge clk_sys_in);
    rst_n_in <= 1'b0;
    strap <= s;
    repeat (3) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    repeat (12) @(posedge clk_sys_in);
    check(24'(i2c_mode), 24'(s), "mode");
  endtask
  task automatic i2c_write(input logic [6:0] a, input logic [23:0] cd, input logic exp);
    logic [31:0] f;
    logic k;
    f = {a, 1'b0, cd};
    u_dshp_bus_master.i2c_start();
    for (int i = 0; i < 4; i++) begin
      u_dshp_bus_master.i2c_byte(f[31-8*i -: 8], k);
      check(24'(k), 24'(exp), "ack");
    end
    u_dshp_bus_master.i2c_stop();
  endtask
  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_spi();
    do_reset(1'b0);
    u_dshp_bus_master.spi_frame(24'h08A5C3, 24);
    wait_cnt(wr_cnt, 1);
    check(wr_last, 24'h08A5C3, "spi write");
    u_dshp_bus_master.spi_frame(24'h091234, 23);
    wait_cnt(ab_cnt, 1);
    repeat (12) @(posedge clk_sys_in);
    check(24'(wr_cnt), 24'h1, "abort wrote");
    u_dshp_bus_master.spi_frame(24'h090F0F, 24);
    wait_cnt(wr_cnt, 2);
    check(wr_last, 24'h090F0F, "after abort");
    u_dshp_bus_master.spi_frame(24'h880000, 24);
    u_dshp_bus_master.spi_frame(24'h0A1234, 24);
    repeat (12) @(posedge clk_sys_in);
    check(24'(wr_cnt), 24'h2, "read frame wrote");
    $display("spi test done");
  endtask
  task automatic t_i2c_wr();
    int base;
    do_reset(1'b1);
    base = wr_cnt;
    for (int s = 0; s < 4; s++) begin
      asel <= s[1:0];
      i2c_write({5'h12, s[1:0]}, {8'h08, 14'h2C00, s[1:0]}, 1'b1);
      wait_cnt(wr_cnt, base + s + 1);
      check(wr_last, {8'h08, 14'h2C00, s[1:0]}, "i2c write");
    end
    $display("i2c write test done");
  endtask
  task automatic t_i2c_miss();
    int base;
    base = wr_cnt;
    asel <= 2'h0;
    i2c_write(7'h49, 24'h081111, 1'b0);
    i2c_write(7'h78, 24'h082222, 1'b0);
    repeat (12) @(posedge clk_sys_in);
    check(24'(wr_cnt), 24'(base), "unaddressed write");
    $display("i2c mismatch test done");
  endtask
  task automatic t_gcall();
    logic k;
    u_dshp_bus_master.i2c_start();
    u_dshp_bus_master.i2c_byte(8'h00, k);
    check(24'(k), 24'h1, "general call ack");
    u_dshp_bus_master.i2c_byte(8'h06, k);
    check(24'(k), 24'h1, "reset byte ack");
    u_dshp_bus_master.i2c_stop();
    wait_cnt(gc_cnt, 1);
    check(24'(gc_cnt), 24'h1, "soft reset");
    $display("general call test done");
  endtask
  task automatic t_i2c_rd();
    logic k;
    logic [7:0] hi, lo;
    u_dshp_bus_master.i2c_start();
    u_dshp_bus_master.i2c_byte(8'h90, k);
    u_dshp_bus_master.i2c_byte(8'h02, k);
    u_dshp_bus_master.i2c_start();
    u_dshp_bus_master.i2c_byte(8'h91, k);
    check(24'(k), 24'h1, "read address ack");
    u_dshp_bus_master.i2c_read(1'b0, hi);
    u_dshp_bus_master.i2c_read(1'b1, lo);
    u_dshp_bus_master.i2c_stop();
    check(24'({hi, lo}), 24'h00C35A, "read data");
    check(24'(rd_cmd), 24'h000002, "read command");
    $display("i2c read test done");
  endtask
  // ----------------------------------------------------------
  // Main sequence and overall watchdog
  // ----------------------------------------------------------
  initial begin
    clk_sys_in = 1'b0;
    rst_n_in = 1'b0;
    strap = 1'b0;
    asel = 2'h0;
    rd_data = 16'hC35A;
    t_spi();
    t_i2c_wr();
    t_i2c_miss();
    t_gcall();
    t_i2c_rd();
    end_sim();
  end
  initial begin
    repeat (100000) @(posedge clk_sys_in);
    miscompares++;
    end_sim();
  end
endmodule

bind dshp_host_port dshp_host_port_monitor #(.FRAME_BITS(FRAME_BITS)) u_dshp_host_port_monitor (
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
  .interface_select_strap_in(interface_select_strap_in), .frame_sel_n_in(frame_sel_n_in),
  .sclk_in(sclk_in), .serial_data_in_in(serial_data_in_in), .scl_in(scl_in),
  .sda_in(sda_in), .address_strap_pin_in(address_strap_pin_in), .rd_data_in(rd_data_in),
  .sda_out(sda_out), .sda_oe_out(sda_oe_out), .i2c_mode_out(i2c_mode_out),
  .wr_valid_out(wr_valid_out), .wr_req_out(wr_req_out), .rd_cmd_out(rd_cmd_out),
  .soft_reset_out(soft_reset_out), .spi_abort_out(spi_abort_out));
